// file: rtl/twp_pkg.sv
package twp_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_TIMER_MODE = 8'h00;
	localparam logic [7:0] OFF_TICK_COUNT = 8'h04;
	localparam logic [7:0] OFF_DIR5 = 8'h08;
	localparam logic [7:0] OFF_DIR6 = 8'h0c;
	localparam logic [7:0] OFF_DIR7 = 8'h10;
	localparam logic [7:0] OFF_PULL_DOWN = 8'h14;
	localparam logic [7:0] OFF_OPEN_DRAIN = 8'h18;
	localparam logic [7:0] OFF_PULL_HIGH = 8'h1c;
	localparam logic [7:0] OFF_WDT_CTRL = 8'h20;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
	// timer mode field positions
	localparam int BIT_GIE = 6;
	localparam int BIT_SRC = 5;
	localparam int BIT_EDGE = 4;
	localparam int BIT_OWNER = 3;
	// watchdog control field positions
	localparam int BIT_WDT_EN = 7;
	localparam int BIT_EXT_SEL = 6;
	// irq mask field positions, pull-down unused bit and timer pin bit
	localparam int BIT_M_EXT = 2;
	localparam int BIT_M_CHG = 1;
	localparam int BIT_M_TOV = 0;
	localparam int BIT_PD_UNUSED = 3;
	localparam int TIMER_PIN_BIT = 4;
	// reset values and irq mask read fill
	localparam logic [7:0] RST_TIMER_MODE = 8'hbf;
	localparam logic [7:0] RST_PULL = 8'hff;
	localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
	localparam logic [7:0] RST_WDT_CTRL = 8'h80;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [2:0] RST_IRQ_MASK = 3'h0;
	localparam logic [4:0] MASK_UPPER_FILL = 5'h1f;
	// timing
	localparam int unsigned CLK_FREQ_KHZ = 200000;
	localparam int unsigned WDT_TIMEOUT_MS = 18;
	localparam int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * CLK_FREQ_KHZ;
	localparam logic [1:0] CYC_DIV_FAST = 2'h1;
	localparam logic [1:0] CYC_DIV_SLOW = 2'h3;
	localparam int PRE_WIDTH = 8;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// low-bit mask for a prescaler tap of n stages
	function automatic logic [7:0] prescale_mask(input logic [3:0] n);
		logic [8:0] full;
		full = (9'h001 << n) - 9'h001;
		return full[7:0];
	endfunction
endpackage

// file: rtl/twp_ctl_if.sv
`timescale 1ns/1ps
interface twp_ctl_if;
	// prescaler group
	logic pre_in_tick;
	logic pre_clear;
	logic [3:0] pre_tap_n;
	logic pre_out_tick;
	// watchdog group
	logic wdt_tick;
	logic wdt_run;
	logic wdt_clear;
	logic wdt_expire;
	modport core(output pre_in_tick, pre_clear, pre_tap_n, wdt_tick, wdt_run, wdt_clear,
		input pre_out_tick, wdt_expire);
	modport pre(input pre_in_tick, pre_clear, pre_tap_n, output pre_out_tick);
	modport wdt(input wdt_tick, wdt_run, wdt_clear, output wdt_expire);
endinterface

// file: rtl/twp_prescaler.sv
`timescale 1ns/1ps
module twp_prescaler (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control group
	twp_ctl_if.pre ctl
);
	logic [twp_pkg::PRE_WIDTH-1:0] count_reg;
	logic [7:0] tap_mask;

	// eight-bit synchronous count, cleared on demand
	always_ff @(posedge aclk) begin
		if (!aresetn || ctl.pre_clear) begin
			count_reg <= '0;
		end else if (ctl.pre_in_tick) begin
			count_reg <= count_reg + 8'h01;
		end
	end

	// tap chosen by ratio, one pass per 2^n input ticks
	assign tap_mask = twp_pkg::prescale_mask(ctl.pre_tap_n);
	assign ctl.pre_out_tick = ctl.pre_in_tick && ((count_reg & tap_mask) == tap_mask);
endmodule

// file: rtl/twp_watchdog.sv
`timescale 1ns/1ps
module twp_watchdog #(
	parameter int unsigned TIMEOUT = twp_pkg::WDT_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control group
	twp_ctl_if.wdt ctl
);
	logic [31:0] count_reg;
	logic at_end;

	assign at_end = (count_reg == 32'(TIMEOUT - 1));

	// count only while enabled, hold while stopped
	always_ff @(posedge aclk) begin
		if (!aresetn || ctl.wdt_clear) begin
			count_reg <= '0;
		end else if (ctl.wdt_run && ctl.wdt_tick) begin
			count_reg <= at_end ? 32'h0 : count_reg + 32'h1;
		end
	end

	// expiry after the base period of ticks
	assign ctl.wdt_expire = ctl.wdt_run && ctl.wdt_tick && at_end && !ctl.wdt_clear;
endmodule

// file: rtl/twp_top.sv
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module twp_top #(
	parameter int unsigned WDT_TIMEOUT = twp_pkg::WDT_TIMEOUT_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core instruction events and code option
	input wire logic irq_disable_instr,
	input wire logic irq_enable_instr,
	input wire logic irq_return_instr,
	input wire logic irq_taken,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic cycle_divider_option,
	input wire logic [7:0] port6_out_data,
	// pins
	input wire logic timer_shared_pin,
	input wire logic [7:0] port6_pin_in,
	output logic [7:0] port5_oe,
	output logic [7:0] port6_oe,
	output logic [7:0] port6_out,
	output logic [1:0] port7_oe,
	output logic [6:0] pull_down_en,
	output logic [7:0] pull_high_en,
	// events
	output logic irq_request,
	output logic port_change_wake,
	output logic wdt_reset_req
);
	twp_ctl_if ctl();
	logic [7:0] timer_mode_reg, tick_count_reg, dir5_reg, dir6_reg, dir7_reg;
	logic [7:0] pull_down_n_reg, open_drain_reg, pull_high_n_reg, wdt_ctrl_reg;
	logic [2:0] irq_mask_reg;
	logic [1:0] cyc_cnt_reg, cyc_last;
	logic icyc_en_reg;
	logic tpin_s1_reg, tpin_s2_reg, tpin_prev_reg;
	logic [7:0] p6_s1_reg, p6_s2_reg, p6_prev_reg;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [7:0] awaddr_reg, wdata_reg, rdata_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [7:0] p5_oe_reg, p6_oe_reg, p6_out_reg;
	logic [1:0] p7_oe_reg;
	logic [6:0] pd_en_reg;
	logic [7:0] ph_en_reg;
	logic irq_req_reg, wake_reg, wdt_rst_reg;
	logic wr_do, wr_hit, tick_wr, owner_wdt, ext_src, tpin_edge, src_tick, tick_inc;
	logic ext_evt, chg_evt, tov_evt;
	logic [7:0] rd_val;
	logic rd_hit;
	assign owner_wdt = timer_mode_reg[twp_pkg::BIT_OWNER];
	assign ext_src = timer_mode_reg[twp_pkg::BIT_SRC];
	// instruction cycle enable from a two or four divider
	assign cyc_last = cycle_divider_option ? twp_pkg::CYC_DIV_SLOW : twp_pkg::CYC_DIV_FAST;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_cnt_reg <= 2'h0;
			icyc_en_reg <= 1'b0;
		end else begin
			icyc_en_reg <= (cyc_cnt_reg == cyc_last);
			cyc_cnt_reg <= (cyc_cnt_reg == cyc_last) ? 2'h0 : cyc_cnt_reg + 2'h1;
		end
	end
	// pin synchronisers plus one stage for edge compare
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tpin_s1_reg <= 1'b0;
			tpin_s2_reg <= 1'b0;
			tpin_prev_reg <= 1'b0;
			p6_s1_reg <= 8'h00;
			p6_s2_reg <= 8'h00;
			p6_prev_reg <= 8'h00;
		end else begin
			tpin_s1_reg <= timer_shared_pin;
			tpin_s2_reg <= tpin_s1_reg;
			tpin_prev_reg <= tpin_s2_reg;
			p6_s1_reg <= port6_pin_in;
			p6_s2_reg <= p6_s1_reg;
			p6_prev_reg <= p6_s2_reg;
		end
	end
	// edge polarity select on the timer pin
	assign tpin_edge = timer_mode_reg[twp_pkg::BIT_EDGE] ? (tpin_prev_reg && !tpin_s2_reg)
		: (!tpin_prev_reg && tpin_s2_reg);
	// internal cycle or external pin transition
	assign src_tick = ext_src ? tpin_edge : icyc_en_reg;
	// prescaler fed by counter source or by watchdog base tick
	assign ctl.pre_in_tick = owner_wdt ? 1'b1 : src_tick;
	// counter taps one stage further than watchdog
	assign ctl.pre_tap_n = {1'b0, timer_mode_reg[2:0]} + (owner_wdt ? 4'h0 : 4'h1);
	assign ctl.pre_clear = owner_wdt ? (watchdog_clear_instr || sleep_instr) : tick_wr;
	// direct source when watchdog owns the prescaler
	assign tick_inc = owner_wdt ? src_tick : ctl.pre_out_tick;
	// watchdog base tick runs regardless of sleep
	assign ctl.wdt_tick = owner_wdt ? ctl.pre_out_tick : 1'b1;
	assign ctl.wdt_run = wdt_ctrl_reg[twp_pkg::BIT_WDT_EN];
	// watchdog clear on clear or sleep instruction
	assign ctl.wdt_clear = watchdog_clear_instr || sleep_instr;
	twp_prescaler pre_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl(ctl.pre)
	);
	twp_watchdog #(.TIMEOUT(WDT_TIMEOUT)) wdog_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl(ctl.wdt)
	);
	// write channel: take address and data in either order
	assign wr_do = !awready_reg && !wready_reg && !bvalid_reg;
	assign wr_hit = (awaddr_reg <= twp_pkg::OFF_IRQ_MASK) && (awaddr_reg[1:0] == 2'h0);
	assign tick_wr = wr_do && (awaddr_reg == twp_pkg::OFF_TICK_COUNT);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= twp_pkg::RESP_OKAY;
			awaddr_reg <= 8'h00;
			wdata_reg <= 8'h00;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				awaddr_reg <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg) begin
				wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
				wready_reg <= 1'b0;
			end
			if (wr_do) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? twp_pkg::RESP_OKAY : twp_pkg::RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end
	// timer mode, global enable driven by instructions
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_mode_reg <= twp_pkg::RST_TIMER_MODE;
		end else begin
			if (wr_do && awaddr_reg == twp_pkg::OFF_TIMER_MODE) begin
				timer_mode_reg <= wdata_reg;
			end
			if (irq_disable_instr || irq_taken) begin
				timer_mode_reg[twp_pkg::BIT_GIE] <= 1'b0;
			end else if (irq_enable_instr || irq_return_instr) begin
				timer_mode_reg[twp_pkg::BIT_GIE] <= 1'b1;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_count_reg <= 8'h00;
		end else if (tick_wr) begin
			tick_count_reg <= wdata_reg;
		end else if (tick_inc) begin
			tick_count_reg <= tick_count_reg + 8'h01;
		end
	end
	// configuration registers and their reset values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir5_reg <= twp_pkg::RST_DIR;
			dir6_reg <= twp_pkg::RST_DIR;
			dir7_reg <= twp_pkg::RST_DIR;
			pull_down_n_reg <= twp_pkg::RST_PULL;
			open_drain_reg <= twp_pkg::RST_OPEN_DRAIN;
			pull_high_n_reg <= twp_pkg::RST_PULL;
			wdt_ctrl_reg <= twp_pkg::RST_WDT_CTRL;
			irq_mask_reg <= twp_pkg::RST_IRQ_MASK;
		end else if (wr_do) begin
			unique case (awaddr_reg)
				twp_pkg::OFF_DIR5: dir5_reg <= wdata_reg;
				twp_pkg::OFF_DIR6: dir6_reg <= wdata_reg;
				twp_pkg::OFF_DIR7: dir7_reg <= wdata_reg;
				twp_pkg::OFF_PULL_DOWN: pull_down_n_reg <= wdata_reg;
				twp_pkg::OFF_OPEN_DRAIN: open_drain_reg <= wdata_reg;
				twp_pkg::OFF_PULL_HIGH: pull_high_n_reg <= wdata_reg;
				twp_pkg::OFF_WDT_CTRL: wdt_ctrl_reg <= wdata_reg;
				twp_pkg::OFF_IRQ_MASK: irq_mask_reg <= wdata_reg[2:0];
				default: ;
			endcase
		end
	end
	// read decode, fill bits
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			twp_pkg::OFF_TIMER_MODE: rd_val = timer_mode_reg;
			twp_pkg::OFF_TICK_COUNT: rd_val = tick_count_reg;
			twp_pkg::OFF_DIR5: rd_val = dir5_reg;
			twp_pkg::OFF_DIR6: rd_val = dir6_reg;
			twp_pkg::OFF_DIR7: rd_val = dir7_reg;
			twp_pkg::OFF_PULL_DOWN: begin
				rd_val = pull_down_n_reg;
				rd_val[twp_pkg::BIT_PD_UNUSED] = 1'b1;
			end
			twp_pkg::OFF_OPEN_DRAIN: rd_val = open_drain_reg;
			twp_pkg::OFF_PULL_HIGH: rd_val = pull_high_n_reg;
			twp_pkg::OFF_WDT_CTRL: rd_val = wdt_ctrl_reg;
			twp_pkg::OFF_IRQ_MASK: rd_val = {twp_pkg::MASK_UPPER_FILL, irq_mask_reg};
			default: rd_hit = 1'b0;
		endcase
	end
	// read channel: one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rresp_reg <= twp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_val;
			rresp_reg <= rd_hit ? twp_pkg::RESP_OKAY : twp_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end
	// /INT falling edge only while pin is the irq input
	assign ext_evt = wdt_ctrl_reg[twp_pkg::BIT_EXT_SEL] && p6_prev_reg[0] && !p6_s2_reg[0];
	assign chg_evt = |(p6_prev_reg ^ p6_s2_reg);
	assign tov_evt = tick_inc && !tick_wr && (tick_count_reg == 8'hff);
	// masked and globally gated irq request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_req_reg <= 1'b0;
			wake_reg <= 1'b0;
			wdt_rst_reg <= 1'b0;
		end else begin
			irq_req_reg <= timer_mode_reg[twp_pkg::BIT_GIE] &&
				|(irq_mask_reg & {ext_evt, chg_evt, tov_evt});
			wake_reg <= chg_evt && irq_mask_reg[twp_pkg::BIT_M_CHG];
			wdt_rst_reg <= ctl.wdt_expire;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p5_oe_reg <= 8'h00;
			p6_oe_reg <= 8'h00;
			p6_out_reg <= 8'h00;
			p7_oe_reg <= 2'h0;
			pd_en_reg <= 7'h00;
			ph_en_reg <= 8'h00;
		end else begin
			p5_oe_reg <= ~dir5_reg;
			// timer pin left to input when counting it
			if (ext_src) begin
				p5_oe_reg[twp_pkg::TIMER_PIN_BIT] <= 1'b0;
			end
			p6_oe_reg <= ~dir6_reg & (~open_drain_reg | ~port6_out_data);
			if (wdt_ctrl_reg[twp_pkg::BIT_EXT_SEL]) begin
				p6_oe_reg[0] <= 1'b0;
			end
			p6_out_reg <= port6_out_data & ~open_drain_reg;
			p7_oe_reg <= ~dir7_reg[1:0];
			pd_en_reg <= ~{pull_down_n_reg[7:4], pull_down_n_reg[2:0]};
			ph_en_reg <= ~pull_high_n_reg;
		end
	end
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign s_axi_rresp = rresp_reg;
	assign port5_oe = p5_oe_reg;
	assign port6_oe = p6_oe_reg;
	assign port6_out = p6_out_reg;
	assign port7_oe = p7_oe_reg;
	assign pull_down_en = pd_en_reg;
	assign pull_high_en = ph_en_reg;
	assign irq_request = irq_req_reg;
	assign port_change_wake = wake_reg;
	assign wdt_reset_req = wdt_rst_reg;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_unscaled_cycle;
		!ext_src && owner_wdt && icyc_en_reg && !tick_wr;
	endsequence
	sequence s_mask_read;
		s_axi_arvalid && arready_reg && s_axi_araddr == twp_pkg::OFF_IRQ_MASK;
	endsequence
	a_gie_clear: assert property ((irq_disable_instr || irq_taken) |=>
		!timer_mode_reg[twp_pkg::BIT_GIE]) else $error("global enable not cleared");
	a_gie_set: assert property ((irq_enable_instr && !irq_disable_instr && !irq_taken)
		|=> timer_mode_reg[twp_pkg::BIT_GIE]) else $error("global enable not set");
	a_tick_unscaled: assert property (s_unscaled_cycle |=>
		tick_count_reg == $past(tick_count_reg) + 8'h01) else $error("tick did not step");
	a_cycle_spacing: assert property (icyc_en_reg && !cycle_divider_option |=>
		!icyc_en_reg) else $error("instruction cycle too fast");
	a_ext_edge_count: assert property (ext_src && owner_wdt && tpin_edge && !tick_wr |=>
		tick_count_reg == $past(tick_count_reg) + 8'h01) else $error("edge not counted");
	a_pre_write_clear: assert property (tick_wr && !owner_wdt |=>
		pre_u.count_reg == 8'h00) else $error("prescaler not cleared by write");
	a_wdt_instr_clear: assert property (watchdog_clear_instr |=>
		wdog_u.count_reg == 32'h0) else $error("watchdog not cleared");
	a_wdt_expire_reset: assert property (ctl.wdt_expire |=> wdt_reset_req)
		else $error("expiry did not reset");
	a_wdt_stopped: assert property (!ctl.wdt_run && !ctl.wdt_clear |=>
		$stable(wdog_u.count_reg)) else $error("watchdog ran while disabled");
	a_mask_fill: assert property (s_mask_read |=> s_axi_rdata[7:3] == 5'h1f)
		else $error("mask upper bits not one");
	a_irq_gated: assert property (!timer_mode_reg[twp_pkg::BIT_GIE] |=> !irq_request)
		else $error("irq passed without global enable");
endmodule

// file: testbench/twp_top_tb.sv
`timescale 1ns/1ps
module twp_top_tb;
	typedef struct {string nm; logic chk; logic [33:0] v;} twp_note_s;
	// bus side stimulus
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	// core events, pins and options
	logic [5:0] ev = 6'h00;
	logic div_opt = 1'b0, tpin = 1'b0;
	logic [7:0] p6d = 8'h00, p6in = 8'hff;
	// design outputs
	logic awready, wready, bvalid, arready, rvalid, irq, wake, wdt;
	logic [1:0] bresp, rresp, p7oe;
	logic [31:0] rdata;
	logic [7:0] p5oe, p6oe, p6out, ph_en;
	logic [6:0] pd_en;
	// bookkeeping
	twp_note_s note_q[$];
	twp_note_s nb;
	int error_cnt = 0, check_count = 0, irq_n = 0, wake_n = 0, wdt_n = 0;
	logic [7:0] q0, q1, r, e8;
	int b, n, e;
	localparam logic [7:0] RA [10] = '{twp_pkg::OFF_TIMER_MODE, twp_pkg::OFF_TICK_COUNT,
		twp_pkg::OFF_DIR5, twp_pkg::OFF_DIR6, twp_pkg::OFF_DIR7, twp_pkg::OFF_PULL_DOWN,
		twp_pkg::OFF_OPEN_DRAIN, twp_pkg::OFF_PULL_HIGH, twp_pkg::OFF_WDT_CTRL,
		twp_pkg::OFF_IRQ_MASK};
	localparam logic [7:0] RV [10] = '{8'hbf, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
		8'hff, 8'h80, 8'hf8};

	twp_top #(.WDT_TIMEOUT(16)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_disable_instr(ev[0]), .irq_enable_instr(ev[1]), .irq_return_instr(ev[2]),
		.irq_taken(ev[3]), .watchdog_clear_instr(ev[4]), .sleep_instr(ev[5]),
		.cycle_divider_option(div_opt), .port6_out_data(p6d), .timer_shared_pin(tpin),
		.port6_pin_in(p6in), .port5_oe(p5oe), .port6_oe(p6oe), .port6_out(p6out),
		.port7_oe(p7oe), .pull_down_en(pd_en), .pull_high_en(ph_en), .irq_request(irq),
		.port_change_wake(wake), .wdt_reset_req(wdt));

	// free running clock
	always #2.5 aclk = ~aclk;

	// event pulse counters
	always @(posedge aclk) begin
		irq_n <= irq_n + ((irq === 1'b1) ? 1 : 0);
		wake_n <= wake_n + ((wake === 1'b1) ? 1 : 0);
		wdt_n <= wdt_n + ((wdt === 1'b1) ? 1 : 0);
	end

	task automatic check(string nm, logic [33:0] seen, logic [33:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// response monitor takes the oldest note
	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready) begin
			nb = note_q.pop_front();
			check(nb.nm, {32'h0, bresp}, nb.v);
		end
		if (rvalid === 1'b1 && rready) begin
			nb = note_q.pop_front();
			if (nb.chk)
				check(nb.nm, {rresp, rdata}, nb.v);
		end
	end

	task automatic tick(int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er = 2'h0);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		note_q.push_back('{$sformatf("bresp %h", a), 1'b1, {32'h0, er}});
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// bready left high so back-to-back writes never drive it twice in a step
		do @(posedge aclk); while (bvalid !== 1'b1);
	endtask

	// e holds response code then data byte
	task automatic rd(logic [7:0] a, logic [9:0] e, logic c, output logic [7:0] q);
		note_q.push_back('{$sformatf("rdata %h", a), c, {e[9:8], 24'h0, e[7:0]}});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		q = rdata[7:0];
	endtask

	task automatic pulse(int k);
		ev[k] <= 1'b1;
		@(posedge aclk);
		ev <= 6'h00;
		@(posedge aclk);
	endtask

	// toggle port 6 pins and count requests
	task automatic poke(logic [7:0] m, int ei, int ew);
		int bi, bw;
		bi = irq_n;
		bw = wake_n;
		p6in <= p6in ^ m;
		tick(12);
		check("irq_request", 34'(irq_n - bi), 34'(ei));
		if (ew >= 0)
			check("port_change_wake", 34'(wake_n - bw != 0), 34'(ew));
	endtask

	task automatic wdt_base;
		pulse(4);
		tick(1);
		b = wdt_n;
	endtask

	task automatic end_sim;
		if (error_cnt == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end

	initial begin
		void'($urandom(70050));
		tick(2);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 10; i++)
			rd(RA[i], {2'h0, RV[i]}, 1'b1, q0);
		wr(8'h02, 8'h55, 2'h2);
		rd(8'h28, 10'h200, 1'b1, q0);
		r = 8'($urandom);
		wr(twp_pkg::OFF_PULL_DOWN, r);
		rd(twp_pkg::OFF_PULL_DOWN, {2'h0, r | 8'h08}, 1'b1, q0);
		tick(3);
		check("pull_down_en", 34'(pd_en), 34'(7'(~{r[7:4], r[2:0]})));
		r = 8'($urandom);
		wr(twp_pkg::OFF_IRQ_MASK, r);
		rd(twp_pkg::OFF_IRQ_MASK, {5'h1f, r[2:0]}, 1'b1, q0);
		wr(twp_pkg::OFF_WDT_CTRL, r & 8'h3f);
		rd(twp_pkg::OFF_WDT_CTRL, {2'h0, r & 8'h3f}, 1'b1, q0);
		wr(twp_pkg::OFF_PULL_HIGH, r);
		wr(twp_pkg::OFF_DIR5, r);
		wr(twp_pkg::OFF_DIR7, r);
		wr(twp_pkg::OFF_OPEN_DRAIN, 8'h00);
		p6d <= ~r;
		wr(twp_pkg::OFF_DIR6, r);
		tick(3);
		check("pull_high_en", 34'(ph_en), 34'(8'(~r)));
		check("port5_oe", 34'(p5oe), 34'(8'(~r & 8'hef)));
		check("port7_oe", 34'(p7oe), 34'(2'(~r[1:0])));
		check("port6_oe", 34'(p6oe), 34'(8'(~r)));
		check("port6_out", 34'(p6out), 34'(8'(~r)));
		wr(twp_pkg::OFF_OPEN_DRAIN, 8'hff);
		wr(twp_pkg::OFF_DIR6, 8'h00);
		p6d <= 8'h0f;
		tick(3);
		check("port6_oe", 34'(p6oe), 34'(8'hf0));
		check("port6_out", 34'(p6out), 34'(8'h00));
		// external pin edges, prescaler on the watchdog
		for (int ed = 0; ed < 2; ed++) begin
			tpin <= ed[0];
			wr(twp_pkg::OFF_TIMER_MODE, 8'ha8 | 8'(ed << 4));
			tick(5);
			wr(twp_pkg::OFF_TICK_COUNT, 8'h00);
			repeat (5) begin
				tpin <= ~ed[0];
				tick(6);
				tpin <= ed[0];
				tick(6);
			end
			tick(6);
			rd(twp_pkg::OFF_TICK_COUNT, 10'h005, 1'b1, q0);
		end
		// internal source, undivided, both cycle options
		wr(twp_pkg::OFF_TIMER_MODE, 8'h88);
		for (int d = 0; d < 2; d++) begin
			div_opt <= d[0];
			tick(8);
			rd(twp_pkg::OFF_TICK_COUNT, 10'h000, 1'b0, q0);
			tick(62);
			rd(twp_pkg::OFF_TICK_COUNT, 10'h000, 1'b0, q1);
			e8 = 8'(64 >> (d + 1));
			check("tick step", 34'(8'(q1 - q0)), 34'(e8));
		end
		div_opt <= 1'b0;
		// counter-owned prescaler ratios
		for (int p = 0; p < 4; p++) begin
			wr(twp_pkg::OFF_TIMER_MODE, 8'h80 | 8'(p));
			rd(twp_pkg::OFF_TICK_COUNT, 10'h000, 1'b0, q0);
			tick((16 << p) - 2);
			rd(twp_pkg::OFF_TICK_COUNT, 10'h000, 1'b0, q1);
			check("tick prescaled", 34'(8'(q1 - q0)), 34'(4));
		end
		// tick writes keep the prescaler empty
		wr(twp_pkg::OFF_TIMER_MODE, 8'h87);
		repeat (3) begin
			wr(twp_pkg::OFF_TICK_COUNT, 8'h00);
			tick(400);
		end
		rd(twp_pkg::OFF_TICK_COUNT, 10'h000, 1'b1, q0);
		// watchdog expiry per ratio
		wr(twp_pkg::OFF_WDT_CTRL, 8'h80);
		for (int p = 0; p < 3; p++) begin
			wr(twp_pkg::OFF_TIMER_MODE, 8'h88 | 8'(p));
			wdt_base();
			n = 0;
			e = 16 << p;
			while (wdt_n == b && n < 2000) begin
				@(posedge aclk);
				n++;
			end
			check("wdt period", 34'(n >= e - 4 && n <= e + 4), 34'(1));
		end
		wr(twp_pkg::OFF_TIMER_MODE, 8'h88);
		wdt_base();
		repeat (10) begin
			tick(8);
			pulse(5);
		end
		check("wdt after sleep", 34'(wdt_n - b), 34'(0));
		wr(twp_pkg::OFF_WDT_CTRL, 8'h00);
		wdt_base();
		tick(300);
		check("wdt stopped", 34'(wdt_n - b), 34'(0));
		// interrupt enable and masking
		wr(twp_pkg::OFF_IRQ_MASK, 8'h02);
		wr(twp_pkg::OFF_TIMER_MODE, 8'h08);
		pulse(1);
		rd(twp_pkg::OFF_TIMER_MODE, 10'h048, 1'b1, q0);
		poke(8'h08, 1, 1);
		pulse(3);
		rd(twp_pkg::OFF_TIMER_MODE, 10'h008, 1'b1, q0);
		poke(8'h08, 0, -1);
		pulse(2);
		rd(twp_pkg::OFF_TIMER_MODE, 10'h048, 1'b1, q0);
		wr(twp_pkg::OFF_IRQ_MASK, 8'h00);
		poke(8'h08, 0, -1);
		pulse(0);
		rd(twp_pkg::OFF_TIMER_MODE, 10'h008, 1'b1, q0);
		wr(twp_pkg::OFF_IRQ_MASK, 8'h04);
		wr(twp_pkg::OFF_WDT_CTRL, 8'h40);
		pulse(1);
		poke(8'h01, 1, -1);
		poke(8'h01, 0, -1);
		wr(twp_pkg::OFF_WDT_CTRL, 8'h00);
		poke(8'h01, 0, -1);
		wr(twp_pkg::OFF_IRQ_MASK, 8'h01);
		wr(twp_pkg::OFF_TICK_COUNT, 8'hfe);
		poke(8'h00, 1, -1);
		tick(4);
		end_sim();
	end
endmodule
